// ==== inc/abu_pkg.sv ====
// package: register map, field positions and reset values of the break unit
package abu_pkg;
    localparam logic [15:0] WAKE_STATUS_OFS = 16'hfe00;
    localparam logic [15:0] FLAG_CLEAR_OFS = 16'hfe03;
    localparam logic [15:0] ADDR_HIGH_OFS = 16'hfe0c;
    localparam logic [15:0] ADDR_LOW_OFS = 16'hfe0d;
    localparam logic [15:0] STATUS_CTRL_OFS = 16'hfe0e;
    localparam int ENABLE_BIT_POS = 7;
    localparam int ACTIVE_BIT_POS = 6;
    localparam int WAIT_FLAG_POS = 1;
    localparam int CLEAR_EN_POS = 7;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // bus answer states
    typedef enum logic [1:0] {BUS_IDLE, BUS_ANSWER} abu_bus_state_type;
endpackage : abu_pkg

// ==== inc/abu_match_if.sv ====
// interface: address compare request and result between the unit and its comparator
`timescale 1ns/1ps
interface abu_match_if;
    logic [15:0] busAddr;
    logic [15:0] breakAddr;
    logic fromCpu;
    logic hit;
    modport unit (output busAddr, output breakAddr, output fromCpu, input hit);
    modport cmp (input busAddr, input breakAddr, input fromCpu, output hit);
endinterface : abu_match_if

// ==== design/abu_comparator.sv ====
// comparator: flags a cpu program address equal to the break address
`timescale 1ns/1ps
module abu_comparator
(
    abu_match_if.cmp m
);
    // only program counter fetches may match, never data traffic
    assign m.hit = m.fromCpu && (m.busAddr == m.breakAddr);
endmodule : abu_comparator

// ==== design/abu_break_unit.sv ====
// break unit: address breakpoint, break state, wake flag and flag protection
`timescale 1ns/1ps
module abu_break_unit
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clkEnable,
    // avalon-mm slave, byte addressed 16-bit space, 8-bit data
    input wire logic [15:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [7:0] avsWriteData,
    output logic [7:0] avsReadData,
    output logic avsWaitRequest,
    // cpu side
    input wire logic [15:0] cpuAddr,
    input wire logic cpuAddrIsPc,
    input wire logic cpuReturnDone,
    input wire logic cpuInWait,
    input wire logic cpuInStop,
    input wire logic testVoltage,
    output logic breakRequest,
    output logic breakActive,
    output logic timerStop,
    output logic watchdogHold,
    output logic stopWake,
    output logic statusClearAllow
);
    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] addrHigh_r;
    logic [7:0] addrLow_r;
    logic enable_r;
    logic active_r;
    logic waitFlag_r;
    logic clearEn_r;
    logic inBreak_r;
    abu_pkg::abu_bus_state_type busState_r;
    abu_pkg::abu_bus_state_type busState_nxt;
    logic addrHit;

    abu_match_if match ();
    assign match.busAddr = cpuAddr;
    assign match.breakAddr = {addrHigh_r, addrLow_r};
    assign match.fromCpu = cpuAddrIsPc;
    assign addrHit = match.hit;

    abu_comparator cmpInst
    (
        .m(match.cmp)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode: request taken in idle, answered one cycle later
    wire accept = (busState_r == abu_pkg::BUS_IDLE) && (avsRead || avsWrite);
    // writes land on the answering edge, where the master still holds them
    wire answering = busState_r == abu_pkg::BUS_ANSWER;
    wire wrEn = answering && avsWrite;
    wire rdEn = accept && avsRead;
    wire selWake = avsAddress == abu_pkg::WAKE_STATUS_OFS;
    wire selClr = avsAddress == abu_pkg::FLAG_CLEAR_OFS;
    wire selHigh = avsAddress == abu_pkg::ADDR_HIGH_OFS;
    wire selLow = avsAddress == abu_pkg::ADDR_LOW_OFS;
    wire selCtrl = avsAddress == abu_pkg::STATUS_CTRL_OFS;
    wire wrHigh = wrEn && selHigh;
    wire wrLow = wrEn && selLow;
    wire wrCtrl = wrEn && selCtrl;
    wire wrWake = wrEn && selWake;
    wire wrClr = wrEn && selClr;
    wire dataEnable = avsWriteData[abu_pkg::ENABLE_BIT_POS];
    wire dataActive = avsWriteData[abu_pkg::ACTIVE_BIT_POS];
    wire dataWait = avsWriteData[abu_pkg::WAIT_FLAG_POS];

    // match breaks need enable; software breaks do not
    wire matchBreak = enable_r && addrHit;
    wire softBreak = wrCtrl && dataActive;
    wire breakEvent = matchBreak || softBreak;
    // a break that lands while asleep marks the wake
    wire wakeEvent = breakEvent && (cpuInWait || cpuInStop);

    // unmapped addresses read zero and ignore writes
    wire [7:0] ctrlRead = {enable_r, active_r, 6'h00};
    wire [7:0] wakeRead = {6'h00, waitFlag_r, 1'b0};
    wire [7:0] clrRead = {clearEn_r, 7'h00};
    wire [7:0] readMux = selHigh ? addrHigh_r :
                         selLow ? addrLow_r :
                         selCtrl ? ctrlRead :
                         selWake ? wakeRead :
                         selClr ? clrRead : abu_pkg::READ_IDLE;

    always_comb
    begin
        busState_nxt = busState_r;
        case (busState_r)
            abu_pkg::BUS_IDLE:
                if (avsRead || avsWrite)
                    busState_nxt = abu_pkg::BUS_ANSWER;
            abu_pkg::BUS_ANSWER:
                busState_nxt = abu_pkg::BUS_IDLE;
            default:
                busState_nxt = abu_pkg::BUS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus handshake; registers answer even in the break state
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busState_r <= abu_pkg::BUS_IDLE;
            avsWaitRequest <= 1'b1;
            avsReadData <= abu_pkg::READ_IDLE;
        end
        else if (clkEnable)
        begin
            busState_r <= busState_nxt;
            avsWaitRequest <= !accept; // low exactly one cycle after taking
            if (rdEn)
                avsReadData <= readMux;
        end
    end

    // break address bytes
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            addrHigh_r <= abu_pkg::BYTE_RESET;
            addrLow_r <= abu_pkg::BYTE_RESET;
        end
        else if (clkEnable)
        begin
            if (wrHigh)
                addrHigh_r <= avsWriteData;
            if (wrLow)
                addrLow_r <= avsWriteData;
        end
    end

    // control bits; a hardware set wins over a same-cycle clear
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            enable_r <= 1'b0;
            active_r <= 1'b0;
            waitFlag_r <= 1'b0;
            clearEn_r <= 1'b0;
        end
        else if (clkEnable)
        begin
            if (wrCtrl)
                enable_r <= dataEnable;
            if (matchBreak || softBreak)
                active_r <= 1'b1;
            else if (wrCtrl && !dataActive)
                active_r <= 1'b0;
            if (wakeEvent)
                waitFlag_r <= 1'b1;
            else if (wrWake && !dataWait)
                waitFlag_r <= 1'b0;
            if (wrClr)
                clearEn_r <= avsWriteData[abu_pkg::CLEAR_EN_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // break state: entered on request, left when the cpu returns
    always_ff @(posedge core_clk)
    begin
        if (reset)
            inBreak_r <= 1'b0;
        else if (clkEnable)
        begin
            if (breakEvent)
                inBreak_r <= 1'b1;
            else if (cpuReturnDone)
                inBreak_r <= 1'b0;
        end
    end

    // outputs registered; request is one cycle so the cpu samples it at
    // its own instruction boundary
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            breakRequest <= 1'b0;
            breakActive <= 1'b0;
            timerStop <= 1'b0;
            watchdogHold <= 1'b0;
            stopWake <= 1'b0;
            statusClearAllow <= 1'b1;
        end
        else if (clkEnable)
        begin
            breakRequest <= breakEvent;
            breakActive <= inBreak_r || breakEvent;
            timerStop <= inBreak_r || breakEvent;
            // watchdog only held off under the test voltage
            watchdogHold <= (inBreak_r || breakEvent) && testVoltage;
            stopWake <= breakEvent && cpuInStop;
            // outside a break status flags clear normally
            statusClearAllow <= !(inBreak_r || breakEvent) || clearEn_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_match_request: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && enable_r && cpuAddrIsPc
        && cpuAddr == {addrHigh_r, addrLow_r} |=> breakRequest)
        else $error("address match did not raise break request");
    a_data_no_match: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && !cpuAddrIsPc && !softBreak |=> !breakRequest)
        else $error("non program address raised a break");
    a_soft_break: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && answering && avsWrite && selCtrl && avsWriteData[6]
        |=> breakRequest && active_r)
        else $error("software break write had no effect");
    a_active_set: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && matchBreak |=> active_r)
        else $error("active bit not set on match");
    a_disabled_gate: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && !enable_r && !softBreak |=> !breakRequest)
        else $error("break raised while disabled");
    a_timer_stop: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && inBreak_r |=> timerStop)
        else $error("timers not stopped during break");
    a_watchdog_hold: assert property (@(posedge core_clk) disable iff (reset)
        watchdogHold |-> $past(testVoltage))
        else $error("watchdog held without test voltage");
    a_wait_flag: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && breakEvent && cpuInWait |=> waitFlag_r)
        else $error("wait flag not set on wake");
    a_flag_protect: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && inBreak_r && !clearEn_r |=> !statusClearAllow)
        else $error("status clear allowed while protected");
    a_bus_answer: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && accept |=> !avsWaitRequest)
        else $error("bus access not answered");

    ////////////////////////////////////////////////////////////////////////
    // further checks; some, such as the stop and wait mode paths, are reached only once by the scenarios

    // a break taken in stop mode has to wake the device
    a_stop_wake: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && breakEvent && cpuInStop |=> stopWake)
        else $error("break in stop mode did not wake");

    // leaving stop through a break is recorded in the wait flag
    a_stop_flag: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && breakEvent && cpuInStop |=> waitFlag_r)
        else $error("wait flag not set on stop wake");

    // matching goes on while the cpu waits
    a_wait_compare: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && matchBreak && cpuInWait |=> breakRequest)
        else $error("match in wait mode raised no break");

    // write of zero clears the active bit unless a match lands with it
    a_active_clear: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && wrCtrl && !dataActive && !breakEvent
        |=> !active_r)
        else $error("active bit not cleared by write of zero");

    // enable bit follows the written value
    a_enable_write: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && wrCtrl |=> enable_r == $past(dataEnable))
        else $error("enable bit did not take the written value");

    // break address bytes take the written value
    a_high_write: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && wrHigh |=> addrHigh_r == $past(avsWriteData))
        else $error("break address high byte not written");

    a_low_write: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && wrLow |=> addrLow_r == $past(avsWriteData))
        else $error("break address low byte not written");

    // write of zero clears the wait flag unless a wake lands with it
    a_wait_clear: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && wrWake && !dataWait && !wakeEvent
        |=> !waitFlag_r)
        else $error("wait flag not cleared by write of zero");

    // outside a break other status flags stay clearable
    a_clear_free: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && !inBreak_r && !breakEvent
        |=> statusClearAllow)
        else $error("status clear blocked outside a break");

    // the flag clear enable lifts the protection
    a_clear_enabled: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && clearEn_r |=> statusClearAllow)
        else $error("status clear blocked with clear enable set");

    // the cpu return ends the break state
    a_break_end: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && cpuReturnDone && !breakEvent |=> !inBreak_r)
        else $error("break state outlived the return");

    // read data is the addressed register, sampled when taken
    a_read_answer: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && rdEn |=> avsReadData == $past(readMux))
        else $error("read data differs from addressed register");

    // waitrequest drops for a single cycle per access
    a_wait_single: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && !avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for more than one cycle");

    // timers run again once the break is over
    a_timer_release: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && !inBreak_r && !breakEvent |=> !timerStop)
        else $error("timers held outside a break");

    // with the test voltage present the watchdog is held in a break
    a_watchdog_on: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && inBreak_r && testVoltage |=> watchdogHold)
        else $error("watchdog not held during break");

    // software breaks do not depend on the enable bit
    a_soft_disabled: assert property (@(posedge core_clk) disable iff (reset)
        clkEnable && softBreak && !enable_r |=> breakRequest)
        else $error("software break lost while disabled");

    // data traffic never reaches the comparator result
    a_data_hit: assert property (@(posedge core_clk) disable iff (reset)
        !cpuAddrIsPc |-> !addrHit)
        else $error("comparator hit on a data address");

    // a low clock enable freezes state and outputs; the bus is held too
    a_freeze_state: assert property (@(posedge core_clk) disable iff (reset)
        !clkEnable |=> $stable(active_r) && $stable(inBreak_r)
        && $stable(breakRequest) && $stable(avsWaitRequest))
        else $error("state moved while clock enable was low");
endmodule : abu_break_unit

// ==== test/abu_cpu_model.sv ====
// cpu partner model: program fetches, break vector fetch and return
`timescale 1ns/1ps
module abu_cpu_model
(
    input wire logic core_clk,
    input wire logic breakRequest,
    input wire logic stopWake,
    output logic [15:0] cpuAddr,
    output logic cpuAddrIsPc,
    output logic cpuReturnDone,
    output logic cpuInWait,
    output logic cpuInStop
);
    logic vecOn;
    logic [15:0] retAddr;
    initial
    begin
        {cpuAddr, cpuAddrIsPc, cpuReturnDone, cpuInWait, cpuInStop} = '0;
        vecOn = 1'b0;
        retAddr = 16'h0000;
    end
    ////////////////////////////////////////////////////////////
    // the instruction counts as finished on the request cycle, so the
    // vector fetch follows at once; this is the worst case for timing
    always @(posedge core_clk)
    begin
        vecOn <= breakRequest;
        if (breakRequest)
        begin
            cpuAddr <= 16'hfffc;
            cpuAddrIsPc <= 1'b1;
            cpuInWait <= 1'b0;
        end
        else if (vecOn)
        begin
            cpuAddr <= 16'h0003; // released bus shows the inverse
            cpuAddrIsPc <= 1'b0;
        end
        if (stopWake)
            cpuInStop <= 1'b0;
    end
    // one program or data fetch; the bus is inverted once released
    task fetch(input logic [15:0] a, input logic p);
        @(posedge core_clk);
        cpuAddr <= a;
        cpuAddrIsPc <= p;
        @(posedge core_clk);
        cpuAddr <= ~a;
        cpuAddrIsPc <= 1'b0;
    endtask : fetch
    // return from the break routine
    task return_from_interrupt_opcode;
        @(posedge core_clk);
        cpuReturnDone <= 1'b1;
        @(posedge core_clk);
        cpuReturnDone <= 1'b0;
    endtask : return_from_interrupt_opcode
    // a woken break routine points its return back at the sleep opcode
    task rewind(input logic [15:0] stacked, input logic woke);
        retAddr <= woke ? stacked - 16'h0001 : stacked;
    endtask : rewind
    task sleep(input logic w, input logic s);
        @(posedge core_clk);
        cpuInWait <= w;
        cpuInStop <= s;
    endtask : sleep
endmodule : abu_cpu_model

// ==== test/address_breakpoint_unit_test.sv ====
// testbench: register access and break behaviour of the break unit
`timescale 1ns/1ps
module address_breakpoint_unit_test;
    logic core_clk, reset, avsRead, avsWrite, avsWaitRequest, testVoltage;
    logic breakRequest, breakActive, timerStop, watchdogHold, stopWake;
    logic statusClearAllow, cpuAddrIsPc, cpuReturnDone, cpuInWait, cpuInStop;
    logic stopSeen, clkEnable;
    logic [15:0] avsAddress, cpuAddr;
    logic [15:0] regs [5];
    logic [7:0] avsWriteData, avsReadData, rd;
    int fails, tests_run;
    abu_break_unit abu_break_unit_i (.core_clk(core_clk), .reset(reset),
        .clkEnable(clkEnable), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .cpuAddr(cpuAddr), .cpuAddrIsPc(cpuAddrIsPc),
        .cpuReturnDone(cpuReturnDone), .cpuInWait(cpuInWait),
        .cpuInStop(cpuInStop), .testVoltage(testVoltage),
        .breakRequest(breakRequest), .breakActive(breakActive),
        .timerStop(timerStop), .watchdogHold(watchdogHold),
        .stopWake(stopWake), .statusClearAllow(statusClearAllow));
    abu_cpu_model cpu (.core_clk(core_clk), .breakRequest(breakRequest),
        .stopWake(stopWake), .cpuAddr(cpuAddr), .cpuAddrIsPc(cpuAddrIsPc),
        .cpuReturnDone(cpuReturnDone), .cpuInWait(cpuInWait),
        .cpuInStop(cpuInStop));
    ////////////////////////////////////////////////////////////
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    // stop wake is a one-cycle pulse, so latch it rather than poll
    always @(posedge core_clk)
        if (stopWake === 1'b1)
            stopSeen <= 1'b1;
    task wrap_up;
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    // avalon request held until waitrequest is sampled low
    task bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int i;
        @(posedge core_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= ~wr;
        avsWriteData <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            if (avsWaitRequest === 1'b0)
                break;
        end
        rd = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        if (i == 20)
        begin
            fails++;
            wrap_up();
        end
        else
            #1;
    endtask : bus
    task rdchk(input string n, input logic [15:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(n, rd, e);
    endtask : rdchk
    task waitActive(input logic v);
        int i;
        for (i = 0; i < 10 && breakActive !== v; i++)
            @(posedge core_clk);
        if (i == 10)
        begin
            fails++;
            wrap_up();
        end
        #1;
    endtask : waitActive
    ////////////////////////////////////////////////////////////
    initial
    begin
        {reset, avsRead, avsWrite, testVoltage, stopSeen} = 5'h10;
        clkEnable = 1'b1;
        {avsAddress, avsWriteData} = '0;
        {fails, tests_run} = '0;
        regs = '{16'hfe00, 16'hfe03, 16'hfe0c, 16'hfe0d, 16'hfe0e};
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        foreach (regs[k])
            rdchk("reset value", regs[k], 8'h00);
        rdchk("unmapped", 16'hfe01, 8'h00);
        bus(1'b1, 16'hfe0c, 8'h12);
        bus(1'b1, 16'hfe0d, 8'h34);
        rdchk("addr high", 16'hfe0c, 8'h12);
        rdchk("addr low", 16'hfe0d, 8'h34);
        cpu.fetch(16'h1234, 1'b1);
        #1 chk("disabled", breakRequest, 1'b0);
        bus(1'b1, 16'hfe0e, 8'h80);
        // a match while the clock enable is low must be ignored
        @(posedge core_clk);
        clkEnable <= 1'b0;
        cpu.fetch(16'h1234, 1'b1);
        #1 chk("frozen", breakRequest, 1'b0);
        @(posedge core_clk);
        clkEnable <= 1'b1;
        cpu.fetch(16'h1234, 1'b0);
        #1 chk("data access", breakRequest, 1'b0);
        cpu.fetch(16'h1235, 1'b1);
        #1 chk("near miss", breakRequest, 1'b0);
        cpu.fetch(16'h1234, 1'b1);
        #1 chk("match", breakRequest, 1'b1);
        chk("timer stop", timerStop, 1'b1);
        rdchk("active bit", 16'hfe0e, 8'hc0);
        chk("watchdog off", watchdogHold, 1'b0);
        chk("clear locked", statusClearAllow, 1'b0);
        @(posedge core_clk);
        testVoltage <= 1'b1;
        bus(1'b1, 16'hfe03, 8'h80);
        rdchk("clear enable", 16'hfe03, 8'h80);
        chk("watchdog held", watchdogHold, 1'b1);
        chk("clear allowed", statusClearAllow, 1'b1);
        bus(1'b1, 16'hfe0e, 8'h80);
        rdchk("active clear", 16'hfe0e, 8'h80);
        cpu.return_from_interrupt_opcode();
        waitActive(1'b0);
        chk("timer run", timerStop, 1'b0);
        bus(1'b1, 16'hfe0e, 8'h40);
        waitActive(1'b1);
        rdchk("soft break", 16'hfe0e, 8'h40);
        bus(1'b1, 16'hfe0e, 8'h80);
        cpu.return_from_interrupt_opcode();
        waitActive(1'b0);
        cpu.sleep(1'b1, 1'b0);
        cpu.fetch(16'h1234, 1'b1);
        #1 chk("wait match", breakRequest, 1'b1);
        rdchk("wait flag", 16'hfe00, 8'h02);
        cpu.rewind(16'h1235, rd[abu_pkg::WAIT_FLAG_POS]);
        bus(1'b1, 16'hfe00, 8'h00);
        chk("rewind", cpu.retAddr[7:0], 8'h34);
        rdchk("flag clear", 16'hfe00, 8'h00);
        bus(1'b1, 16'hfe0e, 8'h00);
        cpu.return_from_interrupt_opcode();
        waitActive(1'b0);
        cpu.sleep(1'b0, 1'b1);
        bus(1'b1, 16'hfe0e, 8'h40);
        waitActive(1'b1);
        repeat (2) @(posedge core_clk);
        #1 chk("stop wake", stopSeen, 1'b1);
        rdchk("stop flag", 16'hfe00, 8'h02);
        wrap_up();
    end
    // a hang anywhere ends the run as a failure
    initial
    begin
        #400000;
        fails++;
        wrap_up();
    end
endmodule : address_breakpoint_unit_test
